// [hw/gpts_top.sv]
// Top: two-group timer sequencer with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Group two runs four states, two with prescaler 01; timer A before B.
// - Group one runs eight states, four with prescaler 01.
// - Group one order: core, lower aux, upper aux, lower aux capture.
// - Interacting timers update in distinct states, one after another.
// - All group actions finish within one basic clock cycle, except a delayed lower aux reload.
// - Either aux timer reloads core on overflow or underflow when enabled.
// - Count-up read just after overflow may show 0000 or 0001.
// - Count-down read just after underflow may show ffff or fffe.
// - Interrupt spacing and toggle output stay exact, except delayed lower reload.
// - Prescaler 01 with input 000 delays lower aux reload one basic cycle.
// - Upper aux reload is never delayed.
module gpts_top
   import gpts_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [15:0] RDATA_O,
   output logic IRQ_O,
   output logic CORE_TOGGLE_O
);
   logic [15:0] ctrl_q;
   logic [15:0] core_q;
   logic [15:0] auxl_q;
   logic [15:0] auxu_q;
   logic [15:0] tb_q;
   logic [15:0] ta_q;
   logic [15:0] capture_reload_register_q;
   logic [4:0] stat_q;
   logic [4:0] mask_q;
   logic [2:0] g1_st_q;
   logic [1:0] g2_st_q;
   logic g1_run_q;
   logic g2_run_q;
   logic core_wrap_q;
   logic pend_l_q;
   logic tick1;
   logic tick2;
   logic [4:0] ev;
   logic wr_ctrl;
   logic wr_core;
   logic wr_auxl;
   logic wr_auxu;
   logic wr_tb;
   logic wr_ta;
   logic wr_cap;
   logic [1:0] block_prescaler_first;
   logic [1:0] block_prescaler_second;
   logic [2:0] isel;
   logic down;
   logic fast1;
   logic delayed_l;
   logic [2:0] g1_last;
   logic [1:0] g2_last;
   gpts_g1_phase_t g1_ph;

   // Step a counter up or down
   function automatic logic [15:0] step(input logic [15:0] v, input logic dn);
      step = dn ? 16'(v - ONE) : 16'(v + ONE);
   endfunction : step

   // Wrap detection for a step
   function automatic logic wraps(input logic [15:0] v, input logic dn);
      wraps = dn ? (v == CNT_RST) : (v == ALL_ONES);
   endfunction : wraps

   assign block_prescaler_first = ctrl_q[CTL_BLOCK_PRESCALER_FIRST_LSB +: 2];
   assign block_prescaler_second = ctrl_q[CTL_BLOCK_PRESCALER_SECOND_LSB +: 2];
   assign isel = ctrl_q[CTL_ISEL_LSB +: 3];
   assign down = ctrl_q[CTL_CORE_DOWN];
   assign fast1 = (block_prescaler_first == BPS_FAST);
   assign delayed_l = fast1 && (isel == ISEL_FAST);
   assign g1_last = fast1 ? 3'(G1_STATES_FAST - 1) : 3'(G1_STATES - 1);
   assign g2_last = (block_prescaler_second == BPS_FAST) ? 2'(G2_STATES_FAST - 1) : 2'(G2_STATES - 1);

   assign wr_ctrl = WR_I && ADDR_I == OFS_CTRL;
   assign wr_core = WR_I && ADDR_I == OFS_CORE;
   assign wr_auxl = WR_I && ADDR_I == OFS_AUXL;
   assign wr_auxu = WR_I && ADDR_I == OFS_AUXU;
   assign wr_tb = WR_I && ADDR_I == OFS_TB;
   assign wr_ta = WR_I && ADDR_I == OFS_TA;
   assign wr_cap = WR_I && ADDR_I == OFS_CAPTURE_RELOAD_REGISTER;

   // Basic clock for each group
   gpts_prescaler u_pre1 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .bps_i(block_prescaler_first),
      .isel_i(isel),
      .tick_o(tick1)
   );

   gpts_prescaler u_pre2 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .bps_i(block_prescaler_second),
      .isel_i(3'h0),
      .tick_o(tick2)
   );

   // Map group one state to phase; two states per phase in the slow sequence
   always_comb
   begin
      unique case (fast1 ? g1_st_q[1:0] : g1_st_q[2:1])
         2'h0: g1_ph = G1_CORE;
         2'h1: g1_ph = G1_AUXL;
         2'h2: g1_ph = G1_AUXU;
         2'h3: g1_ph = G1_CAPT;
      endcase
   end

   // Group one state sequencer
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         g1_st_q <= 3'h0;
         g1_run_q <= 1'b0;
      end
      else if (g1_run_q)
      begin
         g1_st_q <= 3'(g1_st_q + 3'h1);
         if (g1_st_q == g1_last)
         begin
            g1_run_q <= 1'b0;
            g1_st_q <= 3'h0;
         end
      end
      else if (tick1)
      begin
         g1_run_q <= 1'b1;
      end
   end

   // Group two state sequencer
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         g2_st_q <= 2'h0;
         g2_run_q <= 1'b0;
      end
      else if (g2_run_q)
      begin
         g2_st_q <= 2'(g2_st_q + 2'h1);
         if (g2_st_q == g2_last)
         begin
            g2_run_q <= 1'b0;
            g2_st_q <= 2'h0;
         end
      end
      else if (tick2)
      begin
         g2_run_q <= 1'b1;
      end
   end

   // Phase strobes: first state of each phase acts once
   logic g1_act;
   assign g1_act = g1_run_q && (fast1 || !g1_st_q[0]);

   // Core timer: counts in core phase, reloads in aux phases, or in the core phase when the lower reload is delayed
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         core_q <= CNT_RST;
         core_wrap_q <= 1'b0;
         pend_l_q <= 1'b0;
      end
      else if (wr_core)
      begin
         core_q <= WDATA_I;
      end
      else if (g1_act)
      begin
         unique case (g1_ph)
            G1_CORE:
            begin
               if (ctrl_q[CTL_CORE_RUN])
               begin
                  core_q <= step(core_q, down);
                  core_wrap_q <= wraps(core_q, down);
               end
               else
               begin
                  core_wrap_q <= 1'b0;
               end
               if (pend_l_q)
               begin
                  core_q <= auxl_q;
                  pend_l_q <= 1'b0;
               end
            end
            G1_AUXL:
            begin
               if (core_wrap_q && ctrl_q[CTL_RLD_L])
               begin
                  if (delayed_l)
                  begin
                     pend_l_q <= 1'b1;
                  end
                  else
                  begin
                     core_q <= auxl_q;
                  end
               end
            end
            G1_AUXU:
            begin
               if (core_wrap_q && ctrl_q[CTL_RLD_U])
               begin
                  core_q <= auxu_q;
               end
            end
            G1_CAPT:
            begin
            end
         endcase
      end
   end

   // Toggle output follows core wraps once per basic cycle
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         CORE_TOGGLE_O <= 1'b0;
      end
      else if (g1_act && g1_ph == G1_AUXU && core_wrap_q)
      begin
         CORE_TOGGLE_O <= ~CORE_TOGGLE_O;
      end
   end

   // Aux timers: lower captures core in the last phase
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         auxl_q <= CNT_RST;
      end
      else if (wr_auxl)
      begin
         auxl_q <= WDATA_I;
      end
      else if (g1_act && g1_ph == G1_CAPT && ctrl_q[CTL_AUXL_CAP] && core_wrap_q)
      begin
         auxl_q <= core_q;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         auxu_q <= CNT_RST;
      end
      else if (wr_auxu)
      begin
         auxu_q <= WDATA_I;
      end
   end

   // Group two: timer A in state 0, timer B in state 1
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         ta_q <= CNT_RST;
      end
      else if (wr_ta)
      begin
         ta_q <= WDATA_I;
      end
      else if (g2_run_q && g2_st_q == 2'h0 && ctrl_q[CTL_TA_RUN])
      begin
         ta_q <= step(ta_q, 1'b0);
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         tb_q <= CNT_RST;
      end
      else if (wr_tb)
      begin
         tb_q <= WDATA_I;
      end
      else if (g2_run_q && g2_st_q == 2'h1 && ctrl_q[CTL_TB_RUN])
      begin
         tb_q <= step(tb_q, 1'b0);
         if (ctrl_q[CTL_TB_CAPCLR] && wraps(ta_q, 1'b0))
         begin
            tb_q <= CNT_RST;
         end
      end
   end

   // Capture/reload register latches timer B when timer A wraps
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         capture_reload_register_q <= CNT_RST;
      end
      else if (wr_cap)
      begin
         capture_reload_register_q <= WDATA_I;
      end
      else if (g2_run_q && g2_st_q == 2'h1 && ctrl_q[CTL_TA_RUN] && ta_q == CNT_RST)
      begin
         capture_reload_register_q <= tb_q;
      end
   end

   // Control register
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         ctrl_q <= CTRL_RST;
      end
      else if (wr_ctrl)
      begin
         ctrl_q <= WDATA_I;
      end
   end

   // Events
   always_comb
   begin
      ev = '0;
      ev[ST_CORE] = g1_act && g1_ph == G1_AUXU && core_wrap_q;
      ev[ST_AUXL] = g1_act && g1_ph == G1_AUXL && core_wrap_q && ctrl_q[CTL_RLD_L];
      ev[ST_AUXU] = g1_act && g1_ph == G1_AUXU && core_wrap_q && ctrl_q[CTL_RLD_U];
      ev[ST_TA] = g2_run_q && g2_st_q == 2'h0 && ctrl_q[CTL_TA_RUN] && wraps(ta_q, 1'b0);
      ev[ST_TB] = g2_run_q && g2_st_q == 2'h1 && ctrl_q[CTL_TB_RUN] && wraps(tb_q, 1'b0);
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         stat_q <= MASK_RST;
      end
      else
      begin
         stat_q <= (stat_q & ~((WR_I && ADDR_I == OFS_STAT) ? WDATA_I[ST_W-1:0] : 5'h00)) | ev;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         mask_q <= MASK_RST;
      end
      else if (WR_I && ADDR_I == OFS_MASK)
      begin
         mask_q <= WDATA_I[ST_W-1:0];
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         IRQ_O <= 1'b0;
      end
      else
      begin
         IRQ_O <= |(stat_q & mask_q);
      end
   end

   // Read port, data one cycle later
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         RDATA_O <= CNT_RST;
      end
      else if (RD_I)
      begin
         unique case (ADDR_I)
            OFS_CTRL: RDATA_O <= ctrl_q;
            OFS_CORE: RDATA_O <= core_q;
            OFS_AUXL: RDATA_O <= auxl_q;
            OFS_AUXU: RDATA_O <= auxu_q;
            OFS_TB: RDATA_O <= tb_q;
            OFS_TA: RDATA_O <= ta_q;
            OFS_CAPTURE_RELOAD_REGISTER: RDATA_O <= capture_reload_register_q;
            OFS_STAT: RDATA_O <= {11'h000, stat_q};
            OFS_MASK: RDATA_O <= {11'h000, mask_q};
            default: RDATA_O <= CNT_RST;
         endcase
      end
   end
endmodule : gpts_top
`default_nettype wire

// [hw/gpts_pkg.sv]
// Package: constants, offsets and types of the timer sequencer
package gpts_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CORE = 4'h1;
   localparam logic [3:0] OFS_AUXL = 4'h2;
   localparam logic [3:0] OFS_AUXU = 4'h3;
   localparam logic [3:0] OFS_TB = 4'h4;
   localparam logic [3:0] OFS_TA = 4'h5;
   localparam logic [3:0] OFS_CAPTURE_RELOAD_REGISTER = 4'h6;
   localparam logic [3:0] OFS_STAT = 4'h7;
   localparam logic [3:0] OFS_MASK = 4'h8;
   // Control field positions
   localparam int CTL_BLOCK_PRESCALER_FIRST_LSB = 0;
   localparam int CTL_BLOCK_PRESCALER_SECOND_LSB = 2;
   localparam int CTL_ISEL_LSB = 4;
   localparam int CTL_CORE_DOWN = 7;
   localparam int CTL_CORE_RUN = 8;
   localparam int CTL_RLD_L = 9;
   localparam int CTL_RLD_U = 10;
   localparam int CTL_TA_RUN = 11;
   localparam int CTL_TB_RUN = 12;
   localparam int CTL_TB_CAPCLR = 13;
   localparam int CTL_AUXL_CAP = 14;
   // Status bits
   localparam int ST_CORE = 0;
   localparam int ST_AUXL = 1;
   localparam int ST_AUXU = 2;
   localparam int ST_TA = 3;
   localparam int ST_TB = 4;
   localparam int ST_W = 5;
   // Values after reset, and the fast prescaler and input select codes
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [4:0] MASK_RST = 5'h00;
   localparam logic [1:0] BPS_FAST = 2'h1;
   localparam logic [2:0] ISEL_FAST = 3'h0;
   // States per basic cycle: prescaler 01 halves the sequence
   localparam int G1_STATES = 8;
   localparam int G1_STATES_FAST = 4;
   localparam int G2_STATES = 4;
   localparam int G2_STATES_FAST = 2;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   localparam logic [15:0] ONE = 16'h0001;
   typedef enum logic [2:0] {G1_CORE, G1_AUXL, G1_AUXU, G1_CAPT} gpts_g1_phase_t;
endpackage : gpts_pkg

// [hw/gpts_prescaler.sv]
// Block prescaler: basic clock enable for one timer group
`timescale 1ns/1ns
`default_nettype none
module gpts_prescaler
   import gpts_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] bps_i,
   input wire logic [2:0] isel_i,
   output logic tick_o
);
   logic [9:0] cnt_q;
   logic [9:0] lim;

   // Input select adds further binary division
   always_comb
   begin
      lim = 10'((10'h1 << isel_i) - 10'h1);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || cnt_q >= lim)
      begin
         cnt_q <= 10'h000;
      end
      else
      begin
         cnt_q <= cnt_q + 10'h001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (cnt_q >= lim);
      end
   end
   // bps_i only shapes the state count and the lower aux reload delay in the top
   logic unused_bps;
   assign unused_bps = ^bps_i;
endmodule : gpts_prescaler
`default_nettype wire

// [verification/gpts_top_sva.sv]
// Checker: register port, interrupt and toggle assertions
`timescale 1ns/1ns
`default_nettype none
module gpts_top_chk
   import gpts_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [15:0] RDATA_O,
   input wire logic IRQ_O,
   input wire logic CORE_TOGGLE_O
);
   logic [15:0] ctrl_q;
   logic [4:0] mask_q;
   logic [4:0] idle_q;
   default clocking dc @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);
   // Shadow of software registers
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         ctrl_q <= CTRL_RST;
         mask_q <= MASK_RST;
      end
      else if (WR_I && ADDR_I == OFS_CTRL)
         ctrl_q <= WDATA_I;
      else if (WR_I && ADDR_I == OFS_MASK)
         mask_q <= WDATA_I[4:0];
   end
   // Cycles with core stopped
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I || ctrl_q[CTL_CORE_RUN])
         idle_q <= 5'h00;
      else if (idle_q != 5'h1f)
         idle_q <= idle_q + 5'h01;
   end
   sequence s_mask_off;
      WR_I && ADDR_I == OFS_MASK && WDATA_I[4:0] == 5'h00 ##1 1'b1;
   endsequence
   AST_RST: assert property ($fell(RST_I) |-> RDATA_O == 16'h0000 && !IRQ_O && !CORE_TOGGLE_O)
      else $error("outputs not clear after reset");
   AST_RD_HOLD: assert property (!RD_I |=> $stable(RDATA_O))
      else $error("read data moved without a read");
   AST_RD_UNMAP: assert property (RD_I && ADDR_I > OFS_MASK |=> RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   AST_RD_MASK: assert property (RD_I && ADDR_I == OFS_MASK |=> RDATA_O == {11'h000, mask_q})
      else $error("mask read back wrong");
   AST_RD_CTRL: assert property (RD_I && ADDR_I == OFS_CTRL |=> RDATA_O[14:0] == ctrl_q[14:0])
      else $error("control read back wrong");
   AST_MASK_OFF: assert property (s_mask_off |=> !IRQ_O)
      else $error("interrupt high after mask cleared");
   AST_MASK_ZERO: assert property (mask_q == 5'h00 && $past(mask_q) == 5'h00 |-> !IRQ_O)
      else $error("interrupt high with mask zero");
   AST_TGL_IDLE: assert property (idle_q == 5'h1f |-> $stable(CORE_TOGGLE_O))
      else $error("toggle moved with core stopped");
endmodule : gpts_top_chk
bind gpts_top gpts_top_chk i_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
   .CORE_TOGGLE_O(CORE_TOGGLE_O));
`default_nettype wire

// [verification/tb_top.sv]
// Testbench: register, interrupt and reload timing scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import gpts_pkg::*;
;
   logic SYS_CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic [3:0] ADDR_I = 4'h0;
   logic [15:0] WDATA_I = 16'h0000;
   logic WR_I = 1'b0;
   logic RD_I = 1'b0;
   logic [15:0] RDATA_O;
   logic IRQ_O;
   logic CORE_TOGGLE_O;
   int fails = 0;
   int checked = 0;
   always #4 SYS_CLK_I = ~SYS_CLK_I;
   gpts_top i_dut (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
      .CORE_TOGGLE_O(CORE_TOGGLE_O));
   task automatic chk16(input string s, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", s, e, g);
         fails++;
      end
   endtask : chk16
   task automatic chkn(input string s, input int e, input int g);
      checked++;
      if (g != e)
      begin
         $display("unexpected %s expected %0d seen %0d", s, e, g);
         fails++;
      end
   endtask : chkn
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge SYS_CLK_I);
      WR_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= d;
      @(posedge SYS_CLK_I);
      WR_I <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] d;
      @(posedge SYS_CLK_I);
      RD_I <= 1'b1;
      ADDR_I <= a;
      @(posedge SYS_CLK_I);
      RD_I <= 1'b0;
      #1 d = RDATA_O;
      chk16("read data", e, d & m);
   endtask : rdchk
   // Clocks up to the next toggle edge
   task automatic wt(output int n);
      logic last;
      last = CORE_TOGGLE_O;
      n = 0;
      do
      begin
         @(posedge SYS_CLK_I);
         n++;
      end
      while (CORE_TOGGLE_O === last && n < 4000);
      if (n >= 4000)
         fails++;
   endtask : wt
   function automatic logic [15:0] cw(input logic [1:0] b, input logic [2:0] s,
      input logic dn, input logic lo);
      logic [15:0] c;
      c = 16'h0000;
      c[CTL_BLOCK_PRESCALER_FIRST_LSB +: 2] = b;
      c[CTL_ISEL_LSB +: 3] = s;
      c[CTL_CORE_DOWN] = dn;
      c[CTL_CORE_RUN] = 1'b1;
      c[CTL_RLD_L] = lo;
      c[CTL_RLD_U] = !lo;
      return c;
   endfunction : cw
   // Toggle period under a reload setting
   task automatic per(input logic [15:0] c, input logic [15:0] r, output int p);
      int a;
      int b;
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_CORE, r);
      wr(c[CTL_RLD_L] ? OFS_AUXL : OFS_AUXU, r);
      wr(OFS_CTRL, c);
      wt(a);
      wt(a);
      wt(b);
      chkn("spacing", a, b);
      p = b;
      wr(OFS_STAT, 16'h0001 << ST_CORE);
      rdchk(OFS_STAT, 16'h0001 << ST_CORE, 16'h0000);
      wt(a);
      rdchk(OFS_STAT, 16'h0001 << ST_CORE, 16'h0001 << ST_CORE);
   endtask : per
   task automatic t_regs;
      int a;
      for (a = 0; a < 16; a++)
         rdchk(a[3:0], 16'hffff, 16'h0000);
      wr(OFS_CTRL, 16'h607f);
      rdchk(OFS_CTRL, 16'hffff, 16'h607f);
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_MASK, 16'hffff);
      rdchk(OFS_MASK, 16'hffff, {11'h000, 5'h1f});
      wr(OFS_MASK, 16'h0000);
      wr(OFS_AUXU, 16'h1234);
      rdchk(OFS_AUXU, 16'hffff, 16'h1234);
      wr(4'h9, 16'hffff);
      rdchk(4'h9, 16'hffff, 16'h0000);
   endtask : t_regs
   task automatic t_reload;
      int p16;
      int k;
      int p;
      int q;
      per(cw(BPS_FAST, ISEL_FAST, 1'b0, 1'b0), 16'hfff0, p16);
      per(cw(BPS_FAST, ISEL_FAST, 1'b0, 1'b0), 16'hffe0, p);
      k = (p - p16) / 16;
      chkn("basic cycle", 1, int'(k > 0));
      chkn("upper up", 16 * k, p16);
      per(cw(BPS_FAST, ISEL_FAST, 1'b1, 1'b0), 16'h000f, p);
      chkn("upper down", 16 * k, p);
      per(cw(BPS_FAST, ISEL_FAST, 1'b0, 1'b1), 16'hfff0, p);
      chkn("lower late", 17 * k, p);
      per(cw(BPS_FAST, ISEL_FAST, 1'b0, 1'b1), 16'hfff1, p);
      chkn("lower up adj", 16 * k, p);
      per(cw(BPS_FAST, ISEL_FAST, 1'b1, 1'b1), 16'h000e, p);
      chkn("lower down adj", 16 * k, p);
      per(cw(2'h0, ISEL_FAST, 1'b0, 1'b0), 16'hfff0, q);
      per(cw(2'h0, ISEL_FAST, 1'b0, 1'b1), 16'hfff0, p);
      chkn("lower slow bps", q, p);
      per(cw(BPS_FAST, 3'h1, 1'b0, 1'b0), 16'hfff0, q);
      chkn("sel one slower", 1, int'(q > p16));
      per(cw(BPS_FAST, 3'h1, 1'b0, 1'b1), 16'hfff0, p);
      chkn("lower sel one", q, p);
      wr(OFS_AUXL, 16'h0000);
      per(cw(BPS_FAST, ISEL_FAST, 1'b0, 1'b0) | (16'h0001 << CTL_AUXL_CAP), 16'hfff0, p);
      rdchk(OFS_AUXL, 16'hffff, 16'hfff0);
      wr(OFS_CTRL, 16'h0000);
   endtask : t_reload
   task automatic t_irq;
      int n;
      logic [15:0] c;
      c = 16'h0000;
      c[CTL_TA_RUN] = 1'b1;
      wr(OFS_STAT, 16'h001f);
      wr(OFS_TA, 16'hfff0);
      wr(OFS_MASK, 16'h0001 << ST_TA);
      wr(OFS_CTRL, c);
      n = 0;
      while (IRQ_O !== 1'b1 && n < 2000)
      begin
         @(posedge SYS_CLK_I);
         n++;
      end
      chk16("irq raised", 16'h0001, {15'h0000, IRQ_O});
      wr(OFS_MASK, 16'h0000);
      @(posedge SYS_CLK_I);
      #1;
      chk16("irq masked", 16'h0000, {15'h0000, IRQ_O});
      wr(OFS_CTRL, 16'h0000);
      rdchk(OFS_STAT, 16'h0001 << ST_TA, 16'h0001 << ST_TA);
      wr(OFS_STAT, 16'h0001 << ST_TA);
      wr(OFS_MASK, 16'h0001 << ST_TA);
      rdchk(OFS_STAT, 16'h0001 << ST_TA, 16'h0000);
      chk16("irq cleared", 16'h0000, {15'h0000, IRQ_O});
   endtask : t_irq
   task automatic final_report;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (5) @(posedge SYS_CLK_I);
      RST_I <= 1'b0;
      t_regs();
      t_reload();
      t_irq();
      final_report();
   end
   initial
   begin
      repeat (60000) @(posedge SYS_CLK_I);
      fails++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
